// ### rsc_controller.sv
// Design decisions made here: register access over APB and the register offsets.
module rsc_controller #(
  parameter logic [19:0] LSR_FILT_CYC = 20'(rsc_pkg::RSC_LSR_FILT_CYC)
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        external_reset_pin_n,
  input  wire logic        supply_low,
  input  wire logic        watchdog_overflow,
  input  wire logic        halt_exec,
  input  wire logic        watchdog_clear,
  output logic             core_reset,
  output logic [1:0]       reset_class,
  output logic             pc_clear,
  output logic             sp_clear,
  output logic             sp_to_top,
  output logic             irq_disable_all,
  output logic             watchdog_count_clear,
  output logic             timers_off,
  output logic             prescaler_clear,
  output logic             ports_to_input,
  output logic             watchdog_timeout_flag,
  output logic             powerdown_flag,
  output logic [7:0]       watchdog_select_reg,
  output logic             irq
);

  // ==========================================================================
  // Source detection
  // ==========================================================================
  logic                 lsr_en_q;
  logic                 halt_req_q;
  logic                 wdclr_req_q;

  logic                 pin_q;
  logic [19:0]          lsr_cnt_q;
  logic                 lsr_fire;
  logic                 first_q;
  rsc_pkg::rsc_state_t  state_q;

  logic pin_fall;
  logic wd_run;
  logic wd_halt;
  logic halt_any;
  logic wdclr_any;

  assign pin_fall  = pin_q & ~external_reset_pin_n;
  assign wd_run    = watchdog_overflow & (state_q == rsc_pkg::RSC_RUN);
  assign wd_halt   = watchdog_overflow & (state_q == rsc_pkg::RSC_HALTED);
  assign halt_any  = (halt_exec | halt_req_q) & (state_q == rsc_pkg::RSC_RUN);
  assign wdclr_any = watchdog_clear | wdclr_req_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= external_reset_pin_n;
    end
  end

  // A dip must outlast the filter time; a shorter one leaves no trace.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsr_cnt_q <= '0;
    end else if (!supply_low || !lsr_en_q) begin
      lsr_cnt_q <= '0; // RQ3
    end else if (lsr_cnt_q <= LSR_FILT_CYC) begin
      lsr_cnt_q <= lsr_cnt_q + 20'h00001;
    end
  end
  // The supply must still be low when the count hits the limit, so a dip of exactly the filter time is ignored.
  assign lsr_fire = lsr_en_q && supply_low && (lsr_cnt_q == LSR_FILT_CYC); // RQ2 RQ3

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // The core is held in reset while the pin is low or a full cause fired;
  // the powered-down watchdog reset is a one-cycle wake pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= rsc_pkg::RSC_IN_RESET;
    end else if (!external_reset_pin_n || lsr_fire || wd_run) begin
      state_q <= rsc_pkg::RSC_IN_RESET; // RQ1 RQ4
    end else if (state_q == rsc_pkg::RSC_IN_RESET) begin
      state_q <= rsc_pkg::RSC_RUN; // RQ1
    end else if (halt_any) begin
      state_q <= rsc_pkg::RSC_HALTED;
    end else if (wd_halt) begin
      state_q <= rsc_pkg::RSC_RUN; // RQ5
    end
  end

  // First reset after power-up counts as power-on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_q <= 1'b1;
    end else if (state_q == rsc_pkg::RSC_IN_RESET && external_reset_pin_n) begin
      first_q <= 1'b0;
    end
  end

  logic full_now;
  assign full_now = (state_q == rsc_pkg::RSC_IN_RESET) | ~external_reset_pin_n | lsr_fire | wd_run;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset           <= 1'b1;
      reset_class          <= rsc_pkg::RSC_CLASS_FULL;
      pc_clear             <= 1'b1;
      sp_clear             <= 1'b0;
      sp_to_top            <= 1'b1;
      irq_disable_all      <= 1'b1;
      watchdog_count_clear <= 1'b1;
      timers_off           <= 1'b1;
      prescaler_clear      <= 1'b1;
      ports_to_input       <= 1'b1;
    end else begin
      core_reset           <= full_now; // RQ1
      reset_class          <= full_now ? rsc_pkg::RSC_CLASS_FULL :
                              (wd_halt ? rsc_pkg::RSC_CLASS_WAKE : rsc_pkg::RSC_CLASS_NONE); // RQ15
      pc_clear             <= full_now | wd_halt; // RQ1 RQ5
      sp_clear             <= wd_halt; // RQ5
      sp_to_top            <= full_now; // RQ12
      irq_disable_all      <= full_now; // RQ8
      watchdog_count_clear <= full_now | wdclr_any; // RQ9
      timers_off           <= full_now; // RQ10
      prescaler_clear      <= full_now; // RQ10
      ports_to_input       <= full_now; // RQ11
    end
  end

  // ==========================================================================
  // Reset flags
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_timeout_flag <= 1'b0; // RQ6
      powerdown_flag        <= 1'b0; // RQ6
    end else if (first_q && state_q == rsc_pkg::RSC_IN_RESET) begin
      watchdog_timeout_flag <= 1'b0; // RQ6
      powerdown_flag        <= 1'b0; // RQ6
    end else if (wd_halt) begin
      watchdog_timeout_flag <= 1'b1; // RQ5
      powerdown_flag        <= 1'b1; // RQ5
    end else if (wd_run) begin
      watchdog_timeout_flag <= 1'b1; // RQ4
    end else if (halt_any) begin
      watchdog_timeout_flag <= 1'b0; // RQ14
      powerdown_flag        <= 1'b1; // RQ14
    end else if (wdclr_any && !full_now) begin
      powerdown_flag        <= 1'b0; // RQ14
    end
    // Pin and low-supply resets while running leave both flags alone. RQ7
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_select_reg <= rsc_pkg::RSC_WDSEL_RST;
    end else if (full_now) begin
      watchdog_select_reg <= rsc_pkg::RSC_WDSEL_RST; // RQ13
    end else if (psel && penable && pwrite && paddr == rsc_pkg::RSC_OFF_WDSEL) begin
      watchdog_select_reg <= pwdata[7:0];
    end
  end

  // ==========================================================================
  // APB slave
  // ==========================================================================
  logic wr_acc;
  logic rd_acc;
  logic unmapped;
  assign wr_acc   = psel & penable & pwrite & pready;
  assign rd_acc   = psel & ~penable & ~pwrite;
  assign unmapped = (paddr != rsc_pkg::RSC_OFF_CTRL) && (paddr != rsc_pkg::RSC_OFF_STATUS) &&
                    (paddr != rsc_pkg::RSC_OFF_IRQ_ST) && (paddr != rsc_pkg::RSC_OFF_IRQ_MK) &&
                    (paddr != rsc_pkg::RSC_OFF_WDSEL);

  // Ready is raised one cycle after setup, so every access takes two cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & unmapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsr_en_q    <= rsc_pkg::RSC_LSR_EN_RST;
      halt_req_q  <= 1'b0;
      wdclr_req_q <= 1'b0;
    end else begin
      halt_req_q  <= 1'b0;
      wdclr_req_q <= 1'b0;
      if (wr_acc && paddr == rsc_pkg::RSC_OFF_CTRL) begin
        lsr_en_q    <= pwdata[rsc_pkg::RSC_CTRL_LSR_EN_BIT];
        halt_req_q  <= pwdata[rsc_pkg::RSC_CTRL_HALT_BIT];
        wdclr_req_q <= pwdata[rsc_pkg::RSC_CTRL_WDCLR_BIT];
      end
    end
  end

  // ==========================================================================
  // Interrupts
  // ==========================================================================
  logic [rsc_pkg::RSC_EV_W-1:0] ev;
  logic [rsc_pkg::RSC_EV_W-1:0] ist_q;
  logic [rsc_pkg::RSC_EV_W-1:0] imk_q;
  logic [rsc_pkg::RSC_EV_W-1:0] clr;
  assign ev  = {wd_halt, wd_run, lsr_fire, pin_fall};
  assign clr = (wr_acc && paddr == rsc_pkg::RSC_OFF_IRQ_ST) ? pwdata[rsc_pkg::RSC_EV_W-1:0] : '0;

  // A new event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= '0;
    end else begin
      ist_q <= (ist_q & ~clr) | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imk_q <= '0;
    end else if (wr_acc && paddr == rsc_pkg::RSC_OFF_IRQ_MK) begin
      imk_q <= pwdata[rsc_pkg::RSC_EV_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((ist_q & ~clr) | ev) & imk_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_acc) begin
      unique case (paddr)
        rsc_pkg::RSC_OFF_CTRL:   prdata <= {31'h0, lsr_en_q};
        rsc_pkg::RSC_OFF_STATUS: prdata <= {28'h0, reset_class, powerdown_flag, watchdog_timeout_flag};
        rsc_pkg::RSC_OFF_IRQ_ST: prdata <= {28'h0, ist_q};
        rsc_pkg::RSC_OFF_IRQ_MK: prdata <= {28'h0, imk_q};
        rsc_pkg::RSC_OFF_WDSEL:  prdata <= {24'h0, watchdog_select_reg};
        default:                 prdata <= '0;
      endcase
    end
  end

endmodule

// ### rsc_controller_sva.sv
module rsc_controller_sva #(
  parameter logic [19:0] LSR_FILT_CYC = 20'(rsc_pkg::RSC_LSR_FILT_CYC)
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        external_reset_pin_n,
  input wire logic        supply_low,
  input wire logic        watchdog_overflow,
  input wire logic        halt_exec,
  input wire logic        watchdog_clear,
  input wire logic        core_reset,
  input wire logic [1:0]  reset_class,
  input wire logic        pc_clear,
  input wire logic        sp_clear,
  input wire logic        sp_to_top,
  input wire logic        irq_disable_all,
  input wire logic        watchdog_count_clear,
  input wire logic        timers_off,
  input wire logic        prescaler_clear,
  input wire logic        ports_to_input,
  input wire logic        watchdog_timeout_flag,
  input wire logic        powerdown_flag,
  input wire logic [7:0]  watchdog_select_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] lcnt_q;
  logic        en_q;
  logic        halt_q;
  logic        hwr_q;
  wire         wr0 = psel && penable && pready && pwrite && paddr == 8'h00;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // =========================================================================
  // Helpers
  // =========================================================================
  // The halted mode is tracked here because no port shows it directly.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcnt_q <= 20'h0;
      en_q   <= 1'b1;
      halt_q <= 1'b0;
      hwr_q  <= 1'b0;
    end else begin
      lcnt_q <= supply_low ? lcnt_q + 20'h1 : 20'h0;
      if (wr0)
        en_q <= pwdata[0];
      // A halt written over the bus takes effect one cycle after the access.
      hwr_q  <= wr0 && pwdata[1];
      halt_q <= (halt_q || halt_exec || hwr_q) && !watchdog_overflow && !core_reset;
    end
  end
  // =========================================================================
  // Assertions
  // =========================================================================
  a_pin_reset: assert property (
    !external_reset_pin_n |-> ##[0:2] core_reset && pc_clear) else $error("pin low gave no reset");
  a_full_init: assert property (
    core_reset && $past(core_reset) |-> reset_class == 2'b01 && sp_to_top && irq_disable_all && timers_off
      && prescaler_clear && ports_to_input && watchdog_select_reg == 8'h07) else $error("full reset outputs wrong");
  a_wdcnt_clear: assert property (
    $rose(core_reset) || watchdog_clear |-> ##[0:2] watchdog_count_clear) else $error("watchdog count kept");
  a_run_wdt: assert property (
    watchdog_overflow && !halt_q && !core_reset |-> ##[1:2] core_reset && watchdog_timeout_flag
      && $stable(powerdown_flag)) else $error("run watchdog reset wrong");
  a_halt_wake: assert property (
    watchdog_overflow && halt_q |-> ##[1:2] reset_class == 2'b11 && pc_clear && sp_clear && !ports_to_input
      && !core_reset ##[0:2] watchdog_timeout_flag && powerdown_flag) else $error("halt wake wrong");
  a_halt_flags: assert property (
    halt_exec && !core_reset |-> ##[1:2] powerdown_flag && !watchdog_timeout_flag) else $error("halt flags");
  a_wdclr_pd: assert property (
    watchdog_clear && !core_reset |-> ##[1:2] !powerdown_flag) else $error("watchdog clear kept flag");
  a_lsr_fire: assert property (
    en_q && supply_low && lcnt_q == LSR_FILT_CYC |-> ##[0:4] core_reset) else $error("long dip gave no reset");
  a_lsr_short: assert property (
    supply_low && lcnt_q < LSR_FILT_CYC - 20'h3 && external_reset_pin_n && !watchdog_overflow && !core_reset
      |=> !core_reset) else $error("short dip gave reset");
  a_por_flags: assert property (
    $rose(presetn) |-> !watchdog_timeout_flag && !powerdown_flag) else $error("power-on flags set");
  a_pin_keeps: assert property (
    !external_reset_pin_n && !$past(external_reset_pin_n) |-> $stable(watchdog_timeout_flag)
      && $stable(powerdown_flag)) else $error("pin reset changed flags");
  cover property (reset_class == 2'b11);
  cover property ($rose(core_reset) && supply_low);
  cover property ($rose(watchdog_timeout_flag) && powerdown_flag);
endmodule
bind rsc_controller rsc_controller_sva #(.LSR_FILT_CYC(LSR_FILT_CYC)) i_rsc_controller_sva (.*);

// ### rsc_controller_tb_top.sv
module rsc_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, supply_low = 1'b0, go = 1'b0;
  logic [7:0]  paddr = 8'h00, len = 8'h04, seed = 8'h29;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0]  ev = 3'h0;
  logic [1:0]  reset_class;
  logic [7:0]  watchdog_select_reg;
  logic        pready, pslverr, er, core_reset, pc_clear, sp_clear, sp_to_top, irq_disable_all, irq;
  logic        watchdog_count_clear, timers_off, prescaler_clear, ports_to_input, external_reset_pin_n;
  logic        watchdog_timeout_flag, powerdown_flag;
  int          err_total = 0, samples_checked = 0, cyc_n = 0, n_wake = 0, n_rst = 0, e_to, e_pd, e_ist;
  rsc_controller #(.LSR_FILT_CYC(20'd20)) i_rsc_controller (
    .*,
    .watchdog_overflow(ev[0]),
    .halt_exec        (ev[1]),
    .watchdog_clear   (ev[2])
  );
  rsc_reset_src i_rsc_reset_src (.pclk(pclk), .go(go), .len(len), .pin_n(external_reset_pin_n));
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc_n++;
    if (reset_class === 2'b11)
      n_wake++;
    if (core_reset === 1'b1)
      n_rst++;
    if (cyc_n == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  // =========================================================================
  // Tasks
  // =========================================================================
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // An idle edge follows each transfer so psel is never driven twice in one step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic st();
    apb(1'b0, 8'h04, 32'h0);
    chk({30'h0, rd[1:0]}, {30'h0, e_pd[0], e_to[0]});
  endtask
  task automatic pulse(input int b);
    n_rst = 0;
    ev[b] <= 1'b1;
    @(posedge pclk);
    ev <= 3'h0;
    repeat (8) @(posedge pclk);
  endtask
  task automatic dip(input int n);
    n_rst = 0;
    supply_low <= 1'b1;
    repeat (n) @(posedge pclk);
    supply_low <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // =========================================================================
  // Sequence
  // =========================================================================
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    e_to = 0;
    e_pd = 0;
    e_ist = 0;
    st();
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h07);
    apb(1'b0, 8'h3c, 32'h0);
    chk({31'h0, er}, 32'h1);
    pulse(1);
    e_pd = 1;
    st();
    seed = lfsr(seed);
    len <= 8'h03 + {4'h0, seed[3:0]};
    go <= 1'b1;
    n_rst = 0;
    @(posedge pclk);
    go <= 1'b0;
    repeat (30) @(posedge pclk);
    e_ist |= 1;
    chk({31'h0, n_rst >= len}, 32'h1);
    st();
    seed = lfsr(seed);
    apb(1'b1, 8'h10, {24'h0, seed});
    pulse(0);
    e_to = 1;
    e_ist |= 4;
    st();
    chk({31'h0, n_rst > 0}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h07);
    pulse(1);
    e_to = 0;
    pulse(0);
    e_to = 1;
    e_ist |= 8;
    st();
    chk(n_rst, 0);
    chk(n_wake, 1);
    pulse(2);
    e_pd = 0;
    st();
    dip(10);
    chk(n_rst, 0);
    dip(25);
    e_ist |= 2;
    chk({31'h0, n_rst > 0}, 32'h1);
    st();
    apb(1'b1, 8'h00, 32'h0);
    dip(25);
    chk(n_rst, 0);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, e_ist);
    apb(1'b1, 8'h0c, 32'h4);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 8'h08, 32'h4);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 8'h08, 32'hf);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h00, 32'h2);
    e_to = 0;
    e_pd = 1;
    st();
    apb(1'b1, 8'h00, 32'h4);
    e_pd = 0;
    st();
    give_verdict();
  end
endmodule

// ### rsc_pkg.sv
// Functional notes
// RQ1: Pin reset low while running forces program counter zero; fetch restarts after release.
// RQ2: Enabled low-supply reset fires when supply stays low beyond minimum duration.
// RQ3: Low-supply dips of 1 ms or less are ignored, no reset.
// RQ4: Running watchdog time-out equals pin reset, sets time-out flag, keeps power-down flag.
// RQ5: Powered-down watchdog time-out clears only PC and SP, sets both flags.
// RQ6: Power-on pin reset clears time-out and power-down flags.
// RQ7: Pin or low-supply reset while running keeps both flags unchanged.
// RQ8: Power-on reset disables all interrupt sources.
// RQ9: Power-on reset clears watchdog counter; counting restarts immediately.
// RQ10: Power-on reset switches timers off and clears timer prescaler.
// RQ11: Resets set port data and direction to ones, except powered-down watchdog reset.
// RQ12: Power-on reset points stack pointer at top of stack.
// RQ13: Full resets load watchdog select with 0000 0111; powered-down watchdog keeps registers.
// RQ14: Halt sets power-down flag, clears time-out; watchdog clear or power-up clears power-down.
// RQ15: Controller exports reset class separating full reset from powered-down watchdog reset.
package rsc_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] RSC_OFF_CTRL   = 8'h00;
  localparam logic [7:0] RSC_OFF_STATUS = 8'h04;
  localparam logic [7:0] RSC_OFF_IRQ_ST = 8'h08;
  localparam logic [7:0] RSC_OFF_IRQ_MK = 8'h0c;
  localparam logic [7:0] RSC_OFF_WDSEL  = 8'h10;

  // Control fields.
  localparam int RSC_CTRL_LSR_EN_BIT  = 0;
  localparam int RSC_CTRL_HALT_BIT    = 1;
  localparam int RSC_CTRL_WDCLR_BIT   = 2;

  // Status fields.
  localparam int RSC_ST_TO_BIT        = 0;
  localparam int RSC_ST_PD_BIT        = 1;
  localparam int RSC_ST_CLASS_LSB     = 2;

  // Interrupt event bits: pin, low supply, run watchdog, halt watchdog.
  localparam int RSC_EV_W             = 4;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] RSC_WDSEL_RST  = 8'h07;
  localparam logic [7:0] RSC_PORT_RST   = 8'hff;
  localparam logic       RSC_LSR_EN_RST = 1'b1;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam longint RSC_CLK_HZ       = 250_000_000;
  localparam longint RSC_LSR_FILT_US  = 1000;
  localparam longint RSC_LSR_FILT_CYC = (RSC_LSR_FILT_US * RSC_CLK_HZ) / 1_000_000;
  localparam int     RSC_CNT_W        = 20;

  typedef enum logic [1:0] {
    RSC_CLASS_NONE = 2'b00,
    RSC_CLASS_FULL = 2'b01,
    RSC_CLASS_WAKE = 2'b11
  } rsc_class_t;

  typedef enum logic [1:0] {
    RSC_RUN      = 2'b00,
    RSC_IN_RESET = 2'b01,
    RSC_HALTED   = 2'b11
  } rsc_state_t;

endpackage

// ### rsc_reset_src.sv
module rsc_reset_src (
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic [7:0] len,
  output logic            pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q = 8'h00;
  // The reset line has a pull-up, so a released switch reads high at once.
  assign pin_n = cnt_q == 8'h00;
  always_ff @(posedge pclk) begin
    if (go)
      cnt_q <= len;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
  end
endmodule
